// ===== design/lpww_ctl.sv
// controlling agent: APB registers that program and drive the sequencer
module lpww_ctl
  import lpww_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [7:0] wake_src_i,
  lpww_if.ctl lnk
);
  logic [2:0] stby_q;
  logic [2:0] warmup_time_field_q;
  logic osc_sel_q;
  logic slow_q;
  logic [7:0] wake_en_q;
  logic wfi_q;
  logic woke_q;
  logic wr;
  logic rd;
  logic map_ok;

  assign wr = psel_i && penable_i && pwrite_i;
  assign rd = psel_i && !penable_i && !pwrite_i;
  assign map_ok = (paddr_i == LPWW_REG_CTRL) ||
                  (paddr_i == LPWW_REG_WAKE_EN) ||
                  (paddr_i == LPWW_REG_STATUS) || (paddr_i == LPWW_REG_CMD);

  // ========================================================================
  // configuration registers
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      stby_q <= LPWW_STBY_RESET;
      warmup_time_field_q <= LPWW_WARMUP_TIME_FIELD_RESET;
      osc_sel_q <= 1'b0;
      slow_q <= 1'b0;
      wake_en_q <= 8'h00;
    end else if (wr && paddr_i == LPWW_REG_CTRL) begin
      // illegal standby codes are not stored
      if (pwdata_i[2:0] inside {LPWW_STBY_STOP, LPWW_STBY_SLEEP,
                                LPWW_STBY_IDLE})
        stby_q <= pwdata_i[2:0];
      warmup_time_field_q <= pwdata_i[6:4];
      osc_sel_q <= pwdata_i[8];
      slow_q <= pwdata_i[12];
    end else if (wr && paddr_i == LPWW_REG_WAKE_EN) begin
      wake_en_q <= pwdata_i[7:0];
    end
  end

  // ========================================================================
  // wait-for-interrupt pulse and sticky wake flag (set beats clear)
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      wfi_q <= 1'b0;
      woke_q <= 1'b0;
    end else begin
      wfi_q <= wr && paddr_i == LPWW_REG_CMD && pwdata_i[0] &&
               !lnk.in_standby;
      if (lnk.wake_irq) woke_q <= 1'b1;
      else if (wr && paddr_i == LPWW_REG_STATUS && pwdata_i[8])
        woke_q <= 1'b0;
    end
  end

  // ========================================================================
  // APB: no wait states, data prepared in setup cycle
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      prdata_o <= 32'h0000_0000;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o <= psel_i && !penable_i;
      pslverr_o <= psel_i && !penable_i && !map_ok;
      if (rd) begin
        unique case (paddr_i)
          LPWW_REG_CTRL: prdata_o <= {19'h0, slow_q, 3'h0, osc_sel_q,
                                      1'b0, warmup_time_field_q, 1'b0, stby_q};
          LPWW_REG_WAKE_EN: prdata_o <= {24'h0, wake_en_q};
          LPWW_REG_STATUS: prdata_o <= {23'h0, woke_q, 2'h0,
                                        lnk.sys_clk_en, lnk.in_standby,
                                        1'b0, lnk.cur_state};
          default: prdata_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign lnk.stby_mode = stby_q;
  assign lnk.wait_for_interrupt_instr = wfi_q;
  assign lnk.wake_en = wake_en_q;
  assign lnk.wup_time = warmup_time_field_q;
  assign lnk.wup_osc_sel = osc_sel_q;
  assign lnk.slow_mode = slow_q;
  assign lnk.wake_src = wake_src_i;
endmodule : lpww_ctl // lpww_ctl

// ===== design/lpww_dev.sv
// standby sequencer: wake filtering, warm-up counting and clock gating
//
// Chosen here: the wake cause codes and the warm-up busy output.
module lpww_dev
  import lpww_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  lpww_if.dev lnk,
  output logic warmup_busy_o,
  output logic [1:0] wake_cause_o
);
  lpww_state_e state_q;
  logic [LPWW_WUP_CNT_W-1:0] cnt_q;
  logic [LPWW_WK_W-1:0] allow;
  logic [LPWW_WK_W-1:0] hit;
  logic sys_clk_en_q;
  logic wake_irq_q;
  logic ret_slow_q;
  logic [LPWW_WUP_CNT_W-1:0] wup_len;

  // ========================================================================
  // wake filter
  always_comb begin
    unique case (state_q)
      LPWW_ST_IDLE: allow = LPWW_MASK_IDLE;
      LPWW_ST_SLEEP: allow = LPWW_MASK_SLEEP;
      LPWW_ST_STOP: allow = LPWW_MASK_STOP;
      default: allow = '0;
    endcase
  end
  // NMI and watchdog need no enable; other interrupts do; anything else is dropped
  assign hit = lnk.wake_src & allow &
               (lnk.wake_en | 8'hC0);
  // selector set uses a base two bits shorter (a quarter of the count); slow return from SLEEP needs no count, from STOP it still does
  assign wup_len = LPWW_WUP_CNT_W'(1) << (LPWW_WUP_BASE_LOG2 +
                   2 * int'(lnk.wup_time) - (lnk.wup_osc_sel ? 2 : 0));

  // ========================================================================
  // mode sequencing
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      state_q <= LPWW_ST_RUN;
      cnt_q <= '0;
      ret_slow_q <= 1'b0;
    end else begin
      unique case (state_q)
        LPWW_ST_RUN: begin
          if (lnk.wait_for_interrupt_instr) begin
            ret_slow_q <= lnk.slow_mode;
            unique case (lnk.stby_mode)
              LPWW_STBY_STOP: state_q <= LPWW_ST_STOP;
              LPWW_STBY_SLEEP: state_q <= LPWW_ST_SLEEP;
              LPWW_STBY_IDLE: state_q <= LPWW_ST_IDLE;
              default: state_q <= LPWW_ST_RUN;
            endcase
          end
        end
        LPWW_ST_IDLE: if (|hit) state_q <= LPWW_ST_RUN;
        LPWW_ST_SLEEP: begin
          if (|hit) begin
            // slow oscillator kept running: no warm-up back to SLOW
            if (ret_slow_q) begin
              state_q <= LPWW_ST_RUN;
            end else begin
              state_q <= LPWW_ST_WARM;
              cnt_q <= wup_len;
            end
          end
        end
        LPWW_ST_STOP: begin
          if (|hit) begin
            state_q <= LPWW_ST_WARM;
            cnt_q <= wup_len;
          end
        end
        LPWW_ST_WARM: begin
          if (cnt_q <= LPWW_WUP_CNT_W'(1)) begin
            state_q <= LPWW_ST_RUN;
            cnt_q <= '0;
          end else begin
            cnt_q <= cnt_q - LPWW_WUP_CNT_W'(1);
          end
        end
        default: state_q <= LPWW_ST_RUN;
      endcase
    end
  end

  // ========================================================================
  // clock gate and wake notification
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      sys_clk_en_q <= 1'b1;
      wake_irq_q <= 1'b0;
      wake_cause_o <= 2'h0;
    end else begin
      // clock gated off during SLEEP/STOP and warm-up
      sys_clk_en_q <= (state_q == LPWW_ST_RUN || state_q == LPWW_ST_IDLE)
                      && !(state_q == LPWW_ST_RUN && lnk.wait_for_interrupt_instr &&
                      (lnk.stby_mode == LPWW_STBY_STOP ||
                      lnk.stby_mode == LPWW_STBY_SLEEP));
      // pulse when the core may start handling the waking interrupt
      wake_irq_q <= 1'b0;
      if ((state_q == LPWW_ST_IDLE && |hit) ||
          (state_q == LPWW_ST_SLEEP && |hit && ret_slow_q) ||
          (state_q == LPWW_ST_WARM && cnt_q <= LPWW_WUP_CNT_W'(1)))
        wake_irq_q <= 1'b1;
      if (|hit)
        wake_cause_o <= hit[LPWW_WK_NMI] ? 2'h2 :
                        hit[LPWW_WK_WDT] ? 2'h3 : 2'h1;
    end
  end

  // raised on the entry edge so busy spans every warm-up cycle
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      warmup_busy_o <= 1'b0;
    end else begin
      warmup_busy_o <= (state_q == LPWW_ST_STOP && |hit) ||
                       (state_q == LPWW_ST_SLEEP && |hit && !ret_slow_q) ||
                       (state_q == LPWW_ST_WARM &&
                       !(cnt_q <= LPWW_WUP_CNT_W'(1)));
    end
  end

  assign lnk.sys_clk_en = sys_clk_en_q;
  assign lnk.wake_irq = wake_irq_q;
  assign lnk.in_standby = (state_q != LPWW_ST_RUN);
  assign lnk.cur_state = state_q;
endmodule : lpww_dev // lpww_dev

// ===== design/lpww_if.sv
// link between the standby sequencer and its controlling agent
interface lpww_if;
  logic [2:0] stby_mode;
  logic wait_for_interrupt_instr;
  logic [7:0] wake_en;
  logic [2:0] wup_time;
  logic wup_osc_sel;
  logic slow_mode;
  logic [7:0] wake_src;
  logic sys_clk_en;
  logic in_standby;
  logic wake_irq;
  logic [2:0] cur_state;
  modport dev (
    input stby_mode, wait_for_interrupt_instr, wake_en, wup_time, wup_osc_sel, slow_mode,
    wake_src,
    output sys_clk_en, in_standby, wake_irq, cur_state
  );
  modport ctl (
    output stby_mode, wait_for_interrupt_instr, wake_en, wup_time, wup_osc_sel, slow_mode,
    wake_src,
    input sys_clk_en, in_standby, wake_irq, cur_state
  );
endinterface : lpww_if

// ===== design/lpww_pkg.sv
// shared constants and types for the low-power wake-up / warm-up block
// ==========================================================================
package lpww_pkg;
  // ========================================================================
  // standby field encodings
  localparam logic [2:0] LPWW_STBY_STOP = 3'h1;
  localparam logic [2:0] LPWW_STBY_SLEEP = 3'h2;
  localparam logic [2:0] LPWW_STBY_IDLE = 3'h3;
  localparam logic [2:0] LPWW_STBY_RESET = 3'h3;
  // ========================================================================
  // wake source vector bit positions
  localparam int LPWW_WK_EXT = 0;
  localparam int LPWW_WK_RTC = 1;
  localparam int LPWW_WK_CEC = 2;
  localparam int LPWW_WK_RMC = 3;
  localparam int LPWW_WK_OTHER = 4;
  localparam int LPWW_WK_TICK = 5;
  localparam int LPWW_WK_WDT = 6;
  localparam int LPWW_WK_NMI = 7;
  localparam int LPWW_WK_W = 8;
  // sources allowed to wake each standby mode (IDLE, SLEEP, STOP)
  localparam logic [7:0] LPWW_MASK_IDLE = 8'hFF;
  localparam logic [7:0] LPWW_MASK_SLEEP = 8'h8F;
  localparam logic [7:0] LPWW_MASK_STOP = 8'h81;
  // ========================================================================
  // warm-up: count = 2^(8+2*time_field) cycles, 2^(6+2*time_field) with the oscillator selector set
  localparam int LPWW_WUP_BASE_LOG2 = 8;
  localparam int LPWW_WUP_CNT_W = 24;
  localparam logic [2:0] LPWW_WARMUP_TIME_FIELD_RESET = 3'h0;
  // ========================================================================
  // APB register map of the controller side (byte offsets)
  localparam logic [7:0] LPWW_REG_CTRL = 8'h00;
  localparam logic [7:0] LPWW_REG_WAKE_EN = 8'h04;
  localparam logic [7:0] LPWW_REG_STATUS = 8'h08;
  localparam logic [7:0] LPWW_REG_CMD = 8'h0C;
  // ========================================================================
  typedef enum logic [2:0] {
    LPWW_ST_RUN = 3'b000,
    LPWW_ST_IDLE = 3'b001,
    LPWW_ST_SLEEP = 3'b010,
    LPWW_ST_STOP = 3'b011,
    LPWW_ST_WARM = 3'b100
  } lpww_state_e;
endpackage : lpww_pkg

// ===== dv/lpww_chk.sv
// concurrent checks on the link between the sequencer and its controller
module lpww_chk
  import lpww_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [2:0] stby_mode,
  input wire logic wait_for_interrupt_instr,
  input wire logic [7:0] wake_en,
  input wire logic slow_mode,
  input wire logic [7:0] wake_src,
  input wire logic sys_clk_en,
  input wire logic in_standby,
  input wire logic wake_irq,
  input wire logic [2:0] cur_state
);
  // ==========================================================================
  // helper logic
  logic [7:0] armed;
  // nmi and watchdog sources are armed whatever the enable register holds
  assign armed = wake_src & (wake_en | 8'hC0);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_warm_exit;
    cur_state == LPWW_ST_WARM ##1 cur_state == LPWW_ST_RUN;
  endsequence
  // ==========================================================================
  // assertions
  a_idle_filter: assert property (cur_state == LPWW_ST_IDLE && armed == 8'h00
    |=> cur_state == LPWW_ST_IDLE) else $error("idle left without cause");
  a_sleep_filter: assert property (cur_state == LPWW_ST_SLEEP
    && !(|(armed & LPWW_MASK_SLEEP)) |=> cur_state == LPWW_ST_SLEEP)
    else $error("sleep left on a disallowed source");
  a_stop_filter: assert property (cur_state == LPWW_ST_STOP
    && !(|(armed & LPWW_MASK_STOP)) |=> cur_state == LPWW_ST_STOP)
    else $error("stop left on a disallowed source");
  a_idle_wake: assert property (cur_state == LPWW_ST_IDLE && |armed
    |=> cur_state == LPWW_ST_RUN && wake_irq) else $error("idle wake late");
  a_stop_warm: assert property (cur_state == LPWW_ST_STOP
    && |(armed & LPWW_MASK_STOP) |=> cur_state == LPWW_ST_WARM)
    else $error("stop wake skipped warm-up");
  a_slow_sleep: assert property (cur_state == LPWW_ST_SLEEP && slow_mode
    && |(armed & LPWW_MASK_SLEEP) |=> cur_state == LPWW_ST_RUN)
    else $error("slow sleep wake not immediate");
  a_warm_gated: assert property (cur_state == LPWW_ST_WARM |-> !sys_clk_en)
    else $error("clock running during warm-up");
  a_clk_release: assert property (s_warm_exit |-> wake_irq && !sys_clk_en
    ##1 sys_clk_en) else $error("clock release order wrong");
  a_stop_entry: assert property (wait_for_interrupt_instr && cur_state == LPWW_ST_RUN
    && stby_mode == LPWW_STBY_STOP |=> cur_state == LPWW_ST_STOP
    && in_standby && !sys_clk_en) else $error("stop not entered");
  a_sleep_entry: assert property (wait_for_interrupt_instr && cur_state == LPWW_ST_RUN
    && stby_mode == LPWW_STBY_SLEEP |=> cur_state == LPWW_ST_SLEEP)
    else $error("sleep not entered");
  a_reset_run: assert property ($rose(rst_n_i) |-> cur_state == LPWW_ST_RUN
    && sys_clk_en && !wake_irq) else $error("reset did not restore run");
endmodule // lpww_chk

// ===== dv/lpww_test.sv
// self-checking bench: APB controller driving the standby sequencer
module lpww_test
  import lpww_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk_i = 1'b0, rst_n_i = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pready, pslverr, busy, err;
  logic [7:0] paddr = 8'h00, src = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [1:0] cause;
  int fails = 0, cmp_count = 0, warm, n;
  logic [31:0] ctl_t [4] = '{32'h3, 32'h12, 32'h101, 32'h1002};
  logic [7:0] bad_t [4] = '{8'h10, 8'h60, 8'h62, 8'h10};
  logic [7:0] good_t [4] = '{8'h40, 8'h80, 8'h01, 8'h01};
  logic [1:0] cause_t [4] = '{2'h3, 2'h2, 2'h1, 2'h1};
  logic [2:0] state_t [4] = '{3'h1, 3'h2, 3'h3, 3'h2};
  int warm_t [4] = '{0, 1024, 64, 0};
  always #2.5 core_clk_i = ~core_clk_i;
  // ==========================================================================
  // design, link and checker
  lpww_if lnk();
  lpww_ctl lpww_ctl_inst (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .wake_src_i(src), .lnk(lnk.ctl));
  lpww_dev lpww_dev_inst (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .lnk(lnk.dev), .warmup_busy_o(busy), .wake_cause_o(cause));
  lpww_chk lpww_chk_inst (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .stby_mode(lnk.stby_mode), .wait_for_interrupt_instr(lnk.wait_for_interrupt_instr), .wake_en(lnk.wake_en),
    .slow_mode(lnk.slow_mode), .wake_src(lnk.wake_src),
    .sys_clk_en(lnk.sys_clk_en), .in_standby(lnk.in_standby),
    .wake_irq(lnk.wake_irq), .cur_state(lnk.cur_state));
  // ==========================================================================
  // tasks
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge core_clk_i);
    penable <= 1'b1;
    @(posedge core_clk_i);
    while (pready !== 1'b1) @(posedge core_clk_i);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("compares=%0d mismatches=%0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ==========================================================================
  // sequence
  initial begin
    repeat (20000) @(posedge core_clk_i);
    fails++;
    complete_run();
  end
  initial begin
    repeat (8) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    apb(1'b0, LPWW_REG_CTRL, 32'h0); chk(rd, 32'h3);
    apb(1'b0, LPWW_REG_STATUS, 32'h0); chk(rd, 32'h20);
    apb(1'b0, 8'h10, 32'h0); chk({rd[30:0], err}, 32'h1);
    apb(1'b1, LPWW_REG_WAKE_EN, 32'h21);
    apb(1'b0, LPWW_REG_WAKE_EN, 32'h0); chk(rd, 32'h21);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, LPWW_REG_CTRL, ctl_t[i]);
      apb(1'b1, LPWW_REG_CMD, 32'h1);
      src <= bad_t[i];
      repeat (20) @(posedge core_clk_i);
      apb(1'b0, LPWW_REG_STATUS, 32'h0);
      chk(rd & 32'h1F, 32'h10 | 32'(state_t[i]));
      src <= good_t[i];
      warm = 0;
      n = 0;
      // source is held until the wake pulse, as a level interrupt must be
      while (lnk.wake_irq !== 1'b1 && n < 5000) begin
        @(posedge core_clk_i);
        if (busy === 1'b1) warm++;
        n++;
      end
      src <= 8'h00;
      chk(32'(n < 5000), 32'h1);
      chk(32'(warm), 32'(warm_t[i]));
      chk(32'(cause), 32'(cause_t[i]));
      repeat (2) @(posedge core_clk_i);
      apb(1'b0, LPWW_REG_STATUS, 32'h0); chk(rd, 32'h120);
      apb(1'b1, LPWW_REG_STATUS, 32'h100);
      apb(1'b0, LPWW_REG_CTRL, 32'h0); chk(rd, ctl_t[i]);
    end
    apb(1'b1, LPWW_REG_CTRL, 32'h5);
    apb(1'b0, LPWW_REG_CTRL, 32'h0); chk(rd, 32'h2);
    apb(1'b1, LPWW_REG_CTRL, 32'h1);
    apb(1'b1, LPWW_REG_CMD, 32'h1);
    repeat (5) @(posedge core_clk_i);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    apb(1'b0, LPWW_REG_STATUS, 32'h0); chk(rd, 32'h20);
    chk({31'h0, busy}, 32'h0);
    apb(1'b0, LPWW_REG_CTRL, 32'h0); chk(rd, 32'h3);
    complete_run();
  end
endmodule // lpww_test
